// [include/agp_master_pkg.sv]
// constants for the graphics-port bus master and its request fifo
// assumes a 100 MHz ref clock; port clock, grant and status come from
// the system controller and are sampled, never used as clocks
// Contract
// (RL1) data source drives strobes; receiver captures on them
// (RL2) strobe 0 times bits 15:0, 1 times 31:16
// (RL3) 4x: source also drives complement strobes
// (RL4) one request enqueued per clock while pipe low
// (RL5) read buffer full stops low-priority read return
// (RL6) write buffer full stops fast-write initiation
// (RL7) master alone drives 8-bit sideband request bus
// (RL8) sideband strobe times capture; complement 4x only
// (RL9) status valid only while grant low
// (RL10) code 000: low-priority read or flush return
// (RL11) code 001: high-priority read data return
// (RL12) 010/011: master supplies low/high write data
// (RL13) 111 permits start; 100 to 110 reserved
// (RL14) arbiter grants on request; reset negates grant
// (RL15) no reserved code; status changes per grant
package agp_master_pkg;
    localparam int DATA_W = 32;
    localparam int LANE_W = 16;
    localparam int SBA_W = 8;
    localparam int SB_BYTES = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int PORT_CLK_NS = 80;
    localparam int REF_CLK_NS = 10;
    localparam int PORT_CLK_CYCLES = PORT_CLK_NS / REF_CLK_NS;
    // status codes seen with grant
    localparam logic [2:0] ST_RD_LO = 3'h0;
    localparam logic [2:0] ST_RD_HI = 3'h1;
    localparam logic [2:0] ST_WR_LO = 3'h2;
    localparam logic [2:0] ST_WR_HI = 3'h3;
    localparam logic [2:0] ST_START = 3'h7;
    // idle pattern of the sideband bus
    localparam logic [7:0] SBA_IDLE = 8'hff;
    localparam logic [31:0] AD_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {PH_IDLE, PH_PIPE, PH_WRITE, PH_READ} phase_t;

    function automatic logic st_reserved(input logic [2:0] st);
        st_reserved = (st[2] == 1'b1) && (st != ST_START);
    endfunction : st_reserved

    function automatic logic st_is_write(input logic [2:0] st);
        st_is_write = (st == ST_WR_LO) || (st == ST_WR_HI);
    endfunction : st_is_write

    function automatic logic st_is_read(input logic [2:0] st);
        st_is_read = (st == ST_RD_LO) || (st == ST_RD_HI);
    endfunction : st_is_read
endpackage : agp_master_pkg

// [core/req_fifo.sv]
// request fifo between user side and the bus master
// assumes both sides on the same clock; fall-through read data
`timescale 1ns/1ps
module req_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_state_t;

    fifo_state_t state_reg;
    fifo_state_t state_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // handshakes straight from the count
    assign in_ready_out = (state_reg.count != (AW+1)'(DEPTH));
    assign out_valid_out = (state_reg.count != '0);
    assign out_data_out = mem[state_reg.rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_ready_in && out_valid_out;

    // pointer wrap by depth, not by power of two
    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.wr_ptr = (state_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : state_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            state_next.rd_ptr = (state_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : state_reg.rd_ptr + 1'b1;
        end
        state_next.count = state_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[state_reg.wr_ptr] <= in_data_in;
        end
    end
endmodule : req_fifo

// [core/agp_master.sv]
// graphics-port bus master facing a system controller
// assumes port clock, grant, status, strobes and ad come from the
// controller's domain and pass two flip-flops here before use
`timescale 1ns/1ps
module agp_master #(
    parameter int FIFO_DEPTH = agp_master_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // user request side
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic [31:0] req_data_in,
    input wire logic sideband_mode_in,
    input wire logic mode_4x_in,
    // user write data
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [31:0] wr_data_in,
    // user read data
    output logic rd_valid_out,
    output logic [31:0] rd_data_out,
    output logic rd_hi_prio_out,
    input wire logic rd_space_in,
    input wire logic fw_space_in,
    output logic st_error_out,
    // link pins
    input wire logic port_clock_in,
    input wire logic gnt_n_in,
    input wire logic [2:0] st_in,
    output logic req_n_out,
    output logic pipe_n_out,
    output logic rbf_n_out,
    output logic wbf_n_out,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe_out,
    input wire logic [1:0] adstb_in,
    output logic [1:0] adstb_out,
    output logic adstb_oe_out,
    output logic [1:0] adstb_n_out,
    output logic adstb_n_oe_out,
    output logic [7:0] sba_out,
    output logic sbstb_out,
    output logic sbstb_n_out
);
    typedef struct packed {
        logic clk_s1;
        logic clk_s2;
        logic clk_s3;
        logic gnt_s1;
        logic gnt_s2;
        logic [2:0] st_s1;
        logic [2:0] st_s2;
        logic [1:0] stb_s1;
        logic [1:0] stb_s2;
        logic [1:0] stb_s3;
        logic [31:0] ad_s1;
        logic [31:0] ad_s2;
        agp_master_pkg::phase_t phase;
        logic req_n;
        logic pipe_n;
        logic [31:0] ad;
        logic ad_oe;
        logic [1:0] stb;
        logic stb_oe;
        logic [1:0] stbn;
        logic stbn_oe;
        logic [7:0] sba;
        logic sbstb;
        logic sb_busy;
        logic [1:0] sb_idx;
        logic [31:0] sb_word;
        logic rbf_n;
        logic wbf_n;
        logic [31:0] rd_buf;
        logic [1:0] lane_got;
        logic [31:0] rd_data;
        logic rd_valid;
        logic rd_hi;
        logic st_err;
        logic last_gnt;
        logic [2:0] last_st;
    } master_state_t;

    master_state_t state_reg;
    master_state_t state_next;
    logic q_valid;
    logic q_ready;
    logic [31:0] q_data;
    logic pe;
    logic gnt;
    logic [2:0] st;
    logic start_ok;
    logic wr_ok;
    logic rd_ok;
    logic in_read;

    req_fifo #(
        .WIDTH(agp_master_pkg::DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_req_fifo (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .in_valid_in(req_valid_in),
        .in_ready_out(req_ready_out),
        .in_data_in(req_data_in),
        .out_valid_out(q_valid),
        .out_ready_in(q_ready),
        .out_data_out(q_data)
    );

    // port clock rising edge and synced grant/status, stage two only
    assign pe = state_reg.clk_s2 && !state_reg.clk_s3;
    assign gnt = !state_reg.gnt_s2;
    assign st = state_reg.st_s2;
    // (RL9) status only counts under grant
    assign start_ok = pe && gnt && (st == agp_master_pkg::ST_START);
    assign wr_ok = pe && gnt && agp_master_pkg::st_is_write(st);
    assign rd_ok = pe && gnt && agp_master_pkg::st_is_read(st);
    assign in_read = (state_reg.phase == agp_master_pkg::PH_READ);

    // next state: sync chains, link phase, sideband, read capture
    always_comb begin
        logic [1:0] lane_edge;
        logic [1:0] got;
        logic [31:0] buf_n;
        lane_edge = '0;
        got = '0;
        buf_n = '0;
        state_next = state_reg;
        q_ready = 1'b0;
        wr_ready_out = 1'b0;
        state_next.clk_s1 = port_clock_in;
        state_next.clk_s2 = state_reg.clk_s1;
        state_next.clk_s3 = state_reg.clk_s2;
        state_next.gnt_s1 = gnt_n_in;
        state_next.gnt_s2 = state_reg.gnt_s1;
        state_next.st_s1 = st_in;
        state_next.st_s2 = state_reg.st_s1;
        state_next.stb_s1 = adstb_in;
        state_next.stb_s2 = state_reg.stb_s1;
        state_next.stb_s3 = state_reg.stb_s2;
        state_next.ad_s1 = ad_in;
        state_next.ad_s2 = state_reg.ad_s1;
        state_next.rd_valid = 1'b0;
        state_next.st_err = 1'b0;
        // (RL5) throttle low-priority returns when user sink is full
        state_next.rbf_n = rd_space_in;
        // (RL6) refuse fast writes without space
        state_next.wbf_n = fw_space_in;
        if (pe) begin
            state_next.last_gnt = gnt;
            state_next.last_st = st;
            // (RL15) flag reserved codes and mid-grant status changes
            if (gnt && (agp_master_pkg::st_reserved(st)
                    || (state_reg.last_gnt && st != state_reg.last_st))) begin
                state_next.st_err = 1'b1;
            end
            // (RL14) hold request while pipelined work waits
            state_next.req_n = !((q_valid && !sideband_mode_in)
                || state_reg.phase == agp_master_pkg::PH_PIPE);
            case (state_reg.phase)
                agp_master_pkg::PH_PIPE: begin
                    // (RL4) one request per port edge while pipe low
                    if (q_valid && !sideband_mode_in) begin
                        state_next.ad = q_data;
                        q_ready = 1'b1;
                    end else begin
                        state_next.pipe_n = 1'b1;
                        state_next.ad_oe = 1'b0;
                        state_next.phase = agp_master_pkg::PH_IDLE;
                    end
                end
                default: begin
                    state_next.pipe_n = 1'b1;
                    state_next.ad_oe = 1'b0;
                    state_next.stb_oe = 1'b0;
                    state_next.stbn_oe = 1'b0;
                    state_next.phase = agp_master_pkg::PH_IDLE;
                    // (RL13) start only on the permission code
                    if (start_ok && q_valid && !sideband_mode_in) begin
                        state_next.pipe_n = 1'b0;
                        state_next.ad = q_data;
                        state_next.ad_oe = 1'b1;
                        q_ready = 1'b1;
                        state_next.phase = agp_master_pkg::PH_PIPE;
                    end else if (wr_ok && wr_valid_in) begin
                        // (RL12) supply write data on 010/011
                        state_next.ad = wr_data_in;
                        state_next.ad_oe = 1'b1;
                        wr_ready_out = 1'b1;
                        // (RL1) source toggles both lane strobes per word
                        state_next.stb = ~state_reg.stb;
                        state_next.stb_oe = 1'b1;
                        // (RL3) complement pair only in 4x
                        state_next.stbn = state_reg.stb;
                        state_next.stbn_oe = mode_4x_in;
                        state_next.phase = agp_master_pkg::PH_WRITE;
                    end else if (rd_ok) begin
                        // (RL10) (RL11) read return, priority from code
                        state_next.rd_hi = (st == agp_master_pkg::ST_RD_HI);
                        state_next.lane_got = '0;
                        state_next.phase = agp_master_pkg::PH_READ;
                    end
                end
            endcase
            // (RL7) sideband requests, low byte first, no grant needed
            if (state_reg.sb_busy) begin
                state_next.sba = state_reg.sb_word[8*state_reg.sb_idx +: 8];
                // (RL8) one strobe toggle per byte
                state_next.sbstb = !state_reg.sbstb;
                state_next.sb_idx = state_reg.sb_idx + 2'h1;
                state_next.sb_busy = (state_reg.sb_idx != 2'(agp_master_pkg::SB_BYTES - 1));
            end else if (sideband_mode_in && q_valid
                    && state_reg.phase != agp_master_pkg::PH_PIPE) begin
                state_next.sb_word = q_data;
                state_next.sb_busy = 1'b1;
                state_next.sb_idx = '0;
                state_next.sba = agp_master_pkg::SBA_IDLE;
                q_ready = 1'b1;
            end else begin
                state_next.sba = agp_master_pkg::SBA_IDLE;
            end
        end
        // (RL2) lane 0 captured on strobe 0, lane 1 on strobe 1
        if (in_read) begin
            lane_edge = state_reg.stb_s2 ^ state_reg.stb_s3;
            got = state_reg.lane_got | lane_edge;
            buf_n = state_reg.rd_buf;
            if (lane_edge[0]) begin
                buf_n[15:0] = state_reg.ad_s2[15:0];
            end
            if (lane_edge[1]) begin
                buf_n[31:16] = state_reg.ad_s2[31:16];
            end
            state_next.rd_buf = buf_n;
            state_next.lane_got = got;
            if (got == 2'h3) begin
                state_next.rd_data = buf_n;
                state_next.rd_valid = 1'b1;
                state_next.lane_got = '0;
            end
        end
    end

    // reset: grant treated as negated, bus released, pins idle
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg <= '0;
            state_reg.gnt_s1 <= 1'b1;
            state_reg.gnt_s2 <= 1'b1;
            state_reg.phase <= agp_master_pkg::PH_IDLE;
            state_reg.req_n <= 1'b1;
            state_reg.pipe_n <= 1'b1;
            state_reg.ad <= agp_master_pkg::AD_RESET;
            state_reg.sba <= agp_master_pkg::SBA_IDLE;
            state_reg.rbf_n <= 1'b1;
            state_reg.wbf_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign req_n_out = state_reg.req_n;
    assign pipe_n_out = state_reg.pipe_n;
    assign rbf_n_out = state_reg.rbf_n;
    assign wbf_n_out = state_reg.wbf_n;
    assign ad_out = state_reg.ad;
    assign ad_oe_out = state_reg.ad_oe;
    assign adstb_out = state_reg.stb;
    assign adstb_oe_out = state_reg.stb_oe;
    assign adstb_n_out = state_reg.stbn;
    assign adstb_n_oe_out = state_reg.stbn_oe;
    assign sba_out = state_reg.sba;
    assign sbstb_out = state_reg.sbstb;
    // complement only carries timing in 4x; held high otherwise
    assign sbstb_n_out = mode_4x_in ? !state_reg.sbstb : 1'b1;
    assign rd_valid_out = state_reg.rd_valid;
    assign rd_data_out = state_reg.rd_data;
    assign rd_hi_prio_out = state_reg.rd_hi;
    assign st_error_out = state_reg.st_err;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence pipe_start_s;
        $fell(state_reg.pipe_n);
    endsequence
    sequence start_seen_s;
        $past(start_ok);
    endsequence

    pipe_needs_start_a: assert property (pipe_start_s |-> start_seen_s) // RL13
        else $error("pipe asserted without start status");
    pipe_drives_ad_a: assert property (!state_reg.pipe_n |-> state_reg.ad_oe) // RL4
        else $error("pipe low without request on ad");
    pipe_pop_edge_a: assert property ((q_ready && !sideband_mode_in
            && !state_reg.sb_busy) |-> pe) // RL4
        else $error("request dequeued off a port edge");
    strobe_with_data_a: assert property ($changed(state_reg.stb) |-> ##0 state_reg.stb_oe
            && state_reg.ad_oe) // RL1
        else $error("strobe toggled without driven data");
    strobe_pair_a: assert property (state_reg.stbn_oe |-> state_reg.stb_oe
            && state_reg.stbn == ~state_reg.stb) // RL3
        else $error("complement strobe not complementary");
    write_status_a: assert property ($rose(state_reg.stb_oe) |-> $past(wr_ok)) // RL12
        else $error("write data without write status");
    read_grant_a: assert property ($rose(in_read) |-> $past(rd_ok)) // RL9
        else $error("read phase entered without grant");
    read_full_a: assert property (!rd_space_in |=> !state_reg.rbf_n) // RL5
        else $error("read buffer full not signalled");
    write_full_a: assert property (!fw_space_in |=> !state_reg.wbf_n) // RL6
        else $error("write buffer full not signalled");
    sideband_strobe_a: assert property ($changed(state_reg.sbstb) |-> $past(pe)
            && $past(state_reg.sb_busy)) // RL8
        else $error("sideband strobe moved outside a byte");
    reserved_flag_a: assert property ((pe && gnt && agp_master_pkg::st_reserved(st))
            |=> state_reg.st_err) // RL15
        else $error("reserved status not flagged");
endmodule : agp_master

// [test/ctrl_model.sv]
// device-side model: arbiter, status, read return, request and write capture
// assumes the bench makes the port clock and resolves the shared pins
`timescale 1ns/1ps
module ctrl_model (
    input wire logic port_clock_in,
    input wire logic grant_en_in,
    input wire logic [2:0] st_cmd_in,
    input wire logic [31:0] rd_base_in,
    input wire logic mode_4x_in,
    input wire logic req_n_in,
    input wire logic pipe_n_in,
    input wire logic rbf_n_in,
    input wire logic [31:0] ad_in,
    input wire logic ad_oe_in,
    input wire logic [1:0] adstb_in,
    input wire logic adstb_oe_in,
    input wire logic [1:0] adstb_n_in,
    input wire logic adstb_n_oe_in,
    input wire logic [7:0] sba_in,
    input wire logic sbstb_in,
    output logic gnt_n_out = 1'h1,
    output logic [2:0] st_out = 3'h7,
    output logic [31:0] ad_out = 32'h0,
    output logic [1:0] adstb_out = 2'h0
);
    logic [31:0] pipe_q[$];
    logic [31:0] wr_q[$];
    logic [7:0] sb_q[$];
    int cmpl_bad = 0;
    int rd_cnt = 0;
    logic reading = 1'h0;
    logic g;
    logic rd_go;
    logic [1:0] stb_prev = 2'h0;
    logic sb_prev = 1'h0;

    // grant, status and read data move on the falling edge, away from capture
    // start granted only on request, low reads held while full
    // no fast write is ever begun by this model
    always @(negedge port_clock_in) begin
        g = !(grant_en_in && (st_cmd_in != 3'h7 || !req_n_in)
            && (st_cmd_in != 3'h0 || rbf_n_in));
        rd_go = !g && !gnt_n_out && st_out[2:1] == 2'h0;
        st_out <= st_cmd_in;
        gnt_n_out <= g;
        reading <= rd_go;
        // read word, else the released bus wanders
        ad_out <= rd_go ? rd_base_in + rd_cnt : ~ad_out;
    end

    // strobes and captures on the rising port clock
    always @(posedge port_clock_in) begin
        // both lanes strobed per read word
        if (reading) begin
            adstb_out <= ~adstb_out;
            rd_cnt <= rd_cnt + 1;
        end
        // one request per clock while pipe low
        if (!pipe_n_in)
            pipe_q.push_back(ad_in);
        if (ad_oe_in && adstb_oe_in && adstb_in != stb_prev) begin
            wr_q.push_back(ad_in);
            if (mode_4x_in && !(adstb_n_oe_in && adstb_n_in == ~adstb_in))
                cmpl_bad++;
        end
        // only the master's strobe counts; the model's read strobe shows once released
        if (adstb_oe_in)
            stb_prev <= adstb_in;
        // byte per sideband strobe edge; complement unused
        if (sbstb_in != sb_prev && sba_in != 8'hff)
            sb_q.push_back(sba_in);
        sb_prev <= sbstb_in;
    end
endmodule : ctrl_model

// [test/tb_agp_master.sv]
// bench for the graphics-port master against the controller model
// assumes a 10 ns system clock and an unrelated 80 ns port clock
`timescale 1ns/1ps
module tb_agp_master;
    logic ref_clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic port_clock_in = 1'h0;
    logic req_valid_in = 1'h0;
    logic [31:0] req_data_in = 32'h0;
    logic sideband_mode_in = 1'h0;
    logic mode_4x_in = 1'h0;
    logic wr_valid_in = 1'h0;
    logic [31:0] wr_data_in = 32'h0;
    logic rd_space_in = 1'h1;
    logic fw_space_in = 1'h1;
    logic grant_en = 1'h0;
    logic [2:0] st_cmd = 3'h7;
    logic [31:0] rd_base = 32'h3c00_a500;
    logic req_ready_out, wr_ready_out, rd_valid_out, rd_hi_prio_out, st_error_out;
    logic gnt_n_in, req_n_out, pipe_n_out, rbf_n_out, wbf_n_out, ad_oe_out;
    logic adstb_oe_out, adstb_n_oe_out, sbstb_out, sbstb_n_out;
    logic [31:0] rd_data_out, ad_out, ad_m;
    logic [1:0] adstb_out, adstb_n_out, stb_m;
    logic [2:0] st_in;
    logic [7:0] sba_out;
    logic [31:0] rd_got[$];
    int err_seen = 0;
    int bad_count = 0;
    int checks_done = 0;
    // shared pins: the enabled party drives, else the model's value shows
    wire logic [31:0] ad_in = ad_oe_out ? ad_out : ad_m;
    wire logic [1:0] adstb_in = adstb_oe_out ? adstb_out : stb_m;

    agp_master dut_u (.ref_clk_in, .rst_in, .req_valid_in, .req_ready_out, .req_data_in,
        .sideband_mode_in, .mode_4x_in, .wr_valid_in, .wr_ready_out, .wr_data_in,
        .rd_valid_out, .rd_data_out, .rd_hi_prio_out, .rd_space_in, .fw_space_in,
        .st_error_out, .port_clock_in, .gnt_n_in, .st_in, .req_n_out, .pipe_n_out,
        .rbf_n_out, .wbf_n_out, .ad_in, .ad_out, .ad_oe_out, .adstb_in, .adstb_out,
        .adstb_oe_out, .adstb_n_out, .adstb_n_oe_out, .sba_out, .sbstb_out, .sbstb_n_out);
    ctrl_model model_u (.port_clock_in, .grant_en_in(grant_en), .st_cmd_in(st_cmd),
        .rd_base_in(rd_base), .mode_4x_in, .req_n_in(req_n_out), .pipe_n_in(pipe_n_out),
        .rbf_n_in(rbf_n_out), .ad_in, .ad_oe_in(ad_oe_out), .adstb_in,
        .adstb_oe_in(adstb_oe_out), .adstb_n_in(adstb_n_out), .adstb_n_oe_in(adstb_n_oe_out),
        .sba_in(sba_out), .sbstb_in(sbstb_out), .gnt_n_out(gnt_n_in), .st_out(st_in),
        .ad_out(ad_m), .adstb_out(stb_m));

    // clocks; the port clock is offset so its edges never meet ours
    always #5 ref_clk_in = ~ref_clk_in;
    initial begin
        #3;
        forever #40 port_clock_in = ~port_clock_in;
    end

    // read words and status flags seen on the user side, mid-cycle once settled
    always @(negedge ref_clk_in) begin
        if (rd_valid_out === 1'h1) rd_got.push_back(rd_data_out);
        if (st_error_out === 1'h1) err_seen++;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic ports(input int n);
        repeat (n) @(posedge port_clock_in);
        @(negedge ref_clk_in);
    endtask : ports

    // valid stays up between calls; the caller lowers it after the last word
    task automatic push_req(input logic [31:0] w);
        int n;
        n = 0;
        req_data_in = w;
        req_valid_in = 1'h1;
        while (req_ready_out !== 1'h1 && n < 500) begin
            @(negedge ref_clk_in);
            n++;
        end
        @(negedge ref_clk_in);
    endtask : push_req

    task automatic t_fifo_pipe();
        int n;
        n = 0;
        req_valid_in = 1'h1;
        for (int i = 0; i < 20; i++) begin
            req_data_in = 32'h1000_0000 + n;
            if (req_ready_out === 1'h1) n++;
            @(negedge ref_clk_in);
        end
        req_valid_in = 1'h0;
        ports(4);
        check("fifo words taken", agp_master_pkg::FIFO_DEPTH, n);
        check("requests without grant", 32'h0, model_u.pipe_q.size());
        check("bus request", 1'h0, req_n_out);
        grant_en = 1'h1;
        ports(24);
        grant_en = 1'h0;
        check("requests queued", agp_master_pkg::FIFO_DEPTH, model_u.pipe_q.size());
        foreach (model_u.pipe_q[k])
            check("request word", 32'h1000_0000 + k, model_u.pipe_q[k]);
        ports(3);
    endtask : t_fifo_pipe

    task automatic t_sideband();
        sideband_mode_in = 1'h1;
        push_req(32'h0403_0201);
        push_req(32'h0807_0605);
        req_valid_in = 1'h0;
        ports(16);
        check("sideband bytes", 32'h8, model_u.sb_q.size());
        foreach (model_u.sb_q[k])
            check("sideband byte", k + 1, model_u.sb_q[k]);
        check("sideband complement idle", 1'h1, sbstb_n_out);
        mode_4x_in = 1'h1;
        @(negedge ref_clk_in);
        check("sideband complement 4x", !sbstb_out, sbstb_n_out);
        mode_4x_in = 1'h0;
        sideband_mode_in = 1'h0;
    endtask : t_sideband

    task automatic write_word(input logic [2:0] code, input logic [31:0] w);
        int n;
        n = 0;
        st_cmd = code;
        wr_data_in = w;
        wr_valid_in = 1'h1;
        ports(1);
        grant_en = 1'h1;
        while (wr_ready_out !== 1'h1 && n < 500) begin
            @(negedge ref_clk_in);
            n++;
        end
        @(negedge ref_clk_in);
        wr_valid_in = 1'h0;
        grant_en = 1'h0;
        ports(4);
    endtask : write_word

    task automatic t_write();
        write_word(3'h2, 32'h5a5a_c3c3);
        mode_4x_in = 1'h1;
        write_word(3'h3, 32'h9696_1e1e);
        mode_4x_in = 1'h0;
        check("writes taken", 32'h2, model_u.wr_q.size());
        check("low write word", 32'h5a5a_c3c3, model_u.wr_q[0]);
        check("high write word", 32'h9696_1e1e, model_u.wr_q[1]);
        check("complement strobes", 32'h0, model_u.cmpl_bad);
    endtask : t_write

    task automatic read_run(input logic [2:0] code, output int got);
        int c0;
        rd_got.delete();
        c0 = model_u.rd_cnt;
        st_cmd = code;
        ports(1);
        grant_en = 1'h1;
        ports(6);
        grant_en = 1'h0;
        ports(5);
        got = rd_got.size();
        check("read words", model_u.rd_cnt - c0, got);
        foreach (rd_got[k])
            check("read word", rd_base + c0 + k, rd_got[k]);
    endtask : read_run

    task automatic t_read();
        int n;
        read_run(3'h0, n);
        check("low read returned", 1'h1, n > 3);
        check("low priority flag", 1'h0, rd_hi_prio_out);
        rd_space_in = 1'h0;
        fw_space_in = 1'h0;
        ports(1);
        check("read buffer full", 1'h0, rbf_n_out);
        check("write buffer full", 1'h0, wbf_n_out);
        read_run(3'h0, n);
        check("low read while full", 32'h0, n);
        read_run(3'h1, n);
        check("high read returned", 1'h1, n > 3);
        check("high priority flag", 1'h1, rd_hi_prio_out);
        rd_space_in = 1'h1;
        fw_space_in = 1'h1;
    endtask : t_read

    task automatic t_status();
        int e0;
        e0 = err_seen;
        st_cmd = 3'h5;
        ports(6);
        check("status without grant", e0, err_seen);
        grant_en = 1'h1;
        ports(3);
        grant_en = 1'h0;
        check("reserved status flagged", 1'h1, err_seen > e0);
        ports(3);
        e0 = err_seen;
        st_cmd = 3'h2;
        ports(1);
        grant_en = 1'h1;
        ports(3);
        st_cmd = 3'h3;
        ports(3);
        grant_en = 1'h0;
        check("status change flagged", 1'h1, err_seen > e0);
        ports(3);
        st_cmd = 3'h7;
    endtask : t_status

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // main sequence after a three-cycle reset
    initial begin
        repeat (3) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        rst_in = 1'h0;
        check("sideband idle", 8'hff, sba_out);
        check("request idle", 1'h1, req_n_out & pipe_n_out & rbf_n_out & wbf_n_out);
        t_fifo_pipe();
        t_sideband();
        t_write();
        t_read();
        t_status();
        close_out();
    end

    // about 120 port clocks of traffic; far beyond that is a hang
    initial begin
        #200000;
        bad_count++;
        close_out();
    end
endmodule : tb_agp_master
